// ==== core/rsmc_core.sv ====
// register file and radio control logic of the state machine configuration
`timescale 1ns/100ps
// Function
// - clear channel is always, rssi below threshold, no packet, or both.
// - the selected clear test drives the clear output; select resets to 3.
// - after a received packet go to idle, synth ready, transmit or stay.
// - after a sent packet go to idle, synth ready, resend preamble or rx.
// - auto calibration never, on leaving idle, or on returning to idle.
// - setting 3 calibrates on every fourth return from rx or tx to idle.
// - ready goes low after 1, 16, 64 or 256 ripple counter expiries.
// - the power-on wait counts crystal clock cycles, not fixed time.
// - pin radio control enable bit resets to zero and enables pin control.
// - keep-on bit keeps the crystal running in sleep; resets to zero.
module rsmc_core (
	input wire logic mclk,
	input wire logic srst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire rsmc_pkg::rsmc_cmd_s cmd,
	input wire rsmc_pkg::rsmc_evt_s evt,
	input wire logic rssi_below_thresh,
	input wire logic pkt_receiving,
	input wire logic crystal_stable,
	output logic channel_clear_flag,
	output logic chip_ready_n,
	output rsmc_pkg::rsmc_state_e radio_state,
	output logic cal_start,
	output logic preamble_start,
	output logic crystal_oscillator_en,
	output logic pin_radio_control_en
);
	// ======================================================
	// pin synchronisers
	logic [3:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic mosi_s;
	logic crystal_s;

	rsmc_sync #(
		.W(4),
		.RST(rsmc_pkg::PIN_IDLE)
	) i_rsmc_sync (
		.mclk(mclk),
		.srst(srst),
		.d({spi_cs_n, spi_sclk, spi_mosi, crystal_stable}),
		.q(pins_s)
	);

	assign cs_n_s = pins_s[3];
	assign sclk_s = pins_s[2];
	assign mosi_s = pins_s[1];
	assign crystal_s = pins_s[0];

	// ======================================================
	// serial register port
	rsmc_pkg::rsmc_pkt_cfg_s pkt_cfg_q;
	rsmc_pkg::rsmc_cal_cfg_s cal_cfg_q;
	logic sclk_q;
	logic cs_n_q;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [7:0] shin_q;
	logic [7:0] hdr_q;
	logic [7:0] shout_q;
	wire active;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_start;
	wire hdr_done;
	wire byte_done;
	wire data_first;
	wire is_write;
	wire wr_pkt;
	wire wr_cal;
	wire [5:0] addr;
	wire [7:0] rx_byte;
	wire [7:0] wr_byte;
	wire [7:0] rd_byte;

	// edges are found on the synchronised copies only
	assign active = !cs_n_s;
	assign sclk_rise = active && sclk_s && !sclk_q;
	assign sclk_fall = active && !sclk_s && sclk_q;
	assign cs_start = active && cs_n_q;
	assign rx_byte = {shin_q[6:0], mosi_s};
	assign hdr_done = sclk_rise && (bit_cnt_q == rsmc_pkg::HDR_LAST);
	assign byte_done = sclk_rise && (bit_cnt_q == rsmc_pkg::DATA_LAST);
	assign data_first = sclk_fall && (bit_cnt_q == rsmc_pkg::DATA_FIRST);
	assign is_write = !hdr_q[rsmc_pkg::HDR_READ_BIT];
	assign addr = hdr_q[rsmc_pkg::ADDR_MSB:0];
	// further bytes in one frame repeat the access to the same address
	assign bit_cnt_d = byte_done ? rsmc_pkg::DATA_FIRST : bit_cnt_q + 4'h1;

	// address decode; unmapped addresses read zero and drop writes
	assign wr_pkt = byte_done && is_write && (addr == rsmc_pkg::ADDR_PKT_CFG);
	assign wr_cal = byte_done && is_write && (addr == rsmc_pkg::ADDR_CAL_CFG);
	assign wr_byte = rx_byte & rsmc_pkg::CFG_WMASK;
	assign rd_byte = (addr == rsmc_pkg::ADDR_PKT_CFG) ? pkt_cfg_q :
		(addr == rsmc_pkg::ADDR_CAL_CFG) ? cal_cfg_q : rsmc_pkg::RD_NONE;

	// shift in on rising sclk, shift out on falling sclk
	always_ff @(posedge mclk) begin
		if (srst) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			bit_cnt_q <= '0;
			shin_q <= '0;
			hdr_q <= '0;
			shout_q <= '0;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			cs_n_q <= cs_n_s;
			spi_miso_oe <= active;
			if (!active) begin
				bit_cnt_q <= '0;
			end else if (sclk_rise) begin
				bit_cnt_q <= bit_cnt_d;
				shin_q <= rx_byte;
			end
			if (hdr_done) begin
				hdr_q <= rx_byte;
			end
			// status bit leads the header, register data follows it
			if (cs_start) begin
				spi_miso <= chip_ready_n;
				shout_q <= '0;
			end else if (data_first) begin
				spi_miso <= rd_byte[7];
				shout_q <= {rd_byte[6:0], 1'b0};
			end else if (sclk_fall) begin
				spi_miso <= shout_q[7];
				shout_q <= {shout_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pkt_cfg_q <= rsmc_pkg::PKT_CFG_RST;
			cal_cfg_q <= rsmc_pkg::CAL_CFG_RST;
		end else begin
			if (wr_pkt) begin
				pkt_cfg_q <= wr_byte;
			end
			if (wr_cal) begin
				cal_cfg_q <= wr_byte;
			end
		end
	end

	// ======================================================
	// clear channel assessment
	wire [1:0] clr_sel;
	wire clear_d;

	assign clr_sel = pkt_cfg_q.clear_channel_select;
	assign clear_d = (clr_sel == rsmc_pkg::CLR_ALWAYS) ? 1'b1 :
		(clr_sel == rsmc_pkg::CLR_RSSI) ? rssi_below_thresh :
		(clr_sel == rsmc_pkg::CLR_NO_PKT) ? !pkt_receiving :
		(rssi_below_thresh && !pkt_receiving);

	// ======================================================
	// radio state machine
	rsmc_pkg::rsmc_state_e state_d;
	logic preamble_d;

	// end events win over strobes in the same cycle
	always_comb begin
		state_d = radio_state;
		preamble_d = 1'b0;
		unique case (radio_state)
			rsmc_pkg::ST_IDLE: begin
				if (cmd.go_rx)
					state_d = rsmc_pkg::ST_RX;
				else if (cmd.go_tx)
					state_d = rsmc_pkg::ST_TX;
				else if (cmd.go_synth)
					state_d = rsmc_pkg::ST_SYNTH_ON_TX_READY;
				else if (cmd.go_sleep)
					state_d = rsmc_pkg::ST_SLEEP;
			end
			rsmc_pkg::ST_RX: begin
				if (evt.rx_end) begin
					unique case (pkt_cfg_q.after_receive_next_state)
						rsmc_pkg::RXEND_IDLE: state_d = rsmc_pkg::ST_IDLE;
						rsmc_pkg::RXEND_SYNTH:
							state_d = rsmc_pkg::ST_SYNTH_ON_TX_READY;
						rsmc_pkg::RXEND_TX: state_d = rsmc_pkg::ST_TX;
						rsmc_pkg::RXEND_STAY: state_d = rsmc_pkg::ST_RX;
					endcase
				end else if (cmd.go_idle)
					state_d = rsmc_pkg::ST_IDLE;
				else if (cmd.go_tx)
					state_d = rsmc_pkg::ST_TX;
			end
			rsmc_pkg::ST_TX: begin
				if (evt.tx_end) begin
					unique case (pkt_cfg_q.after_transmit_next_state)
						rsmc_pkg::TXEND_IDLE: state_d = rsmc_pkg::ST_IDLE;
						rsmc_pkg::TXEND_SYNTH:
							state_d = rsmc_pkg::ST_SYNTH_ON_TX_READY;
						rsmc_pkg::TXEND_STAY: preamble_d = 1'b1;
						rsmc_pkg::TXEND_RX: state_d = rsmc_pkg::ST_RX;
					endcase
				end else if (cmd.go_idle)
					state_d = rsmc_pkg::ST_IDLE;
			end
			rsmc_pkg::ST_SYNTH_ON_TX_READY: begin
				if (cmd.go_tx)
					state_d = rsmc_pkg::ST_TX;
				else if (cmd.go_rx)
					state_d = rsmc_pkg::ST_RX;
				else if (cmd.go_idle)
					state_d = rsmc_pkg::ST_IDLE;
			end
			rsmc_pkg::ST_SLEEP: begin
				if (cmd.go_idle)
					state_d = rsmc_pkg::ST_IDLE;
			end
			default: state_d = rsmc_pkg::ST_IDLE;
		endcase
	end

	// ======================================================
	// synthesizer calibration
	logic [1:0] cal_cnt_q;
	wire [1:0] cal_mode;
	wire leave_idle;
	wire back_idle;
	wire count_back;
	wire cal_d;

	assign cal_mode = cal_cfg_q.synth_auto_calibration;
	assign leave_idle = (radio_state == rsmc_pkg::ST_IDLE) &&
		(state_d != rsmc_pkg::ST_IDLE) && (state_d != rsmc_pkg::ST_SLEEP);
	assign back_idle = ((radio_state == rsmc_pkg::ST_RX) ||
		(radio_state == rsmc_pkg::ST_TX)) && (state_d == rsmc_pkg::ST_IDLE);
	assign count_back = back_idle && (cal_mode == rsmc_pkg::CAL_EVERY4);
	assign cal_d = (cmd.calibrate_strobe && radio_state == rsmc_pkg::ST_IDLE)
		|| (cal_mode == rsmc_pkg::CAL_FROM_IDLE && leave_idle)
		|| (cal_mode == rsmc_pkg::CAL_TO_IDLE && back_idle)
		|| (count_back && cal_cnt_q == rsmc_pkg::CAL_LAST);

	always_ff @(posedge mclk) begin
		if (srst) begin
			cal_cnt_q <= '0;
		end else if (count_back) begin
			cal_cnt_q <= cal_cnt_q + 2'h1;
		end
	end

	// ======================================================
	// power-on wait before chip ready
	logic [5:0] ripple_q;
	logic [8:0] expire_q;
	wire [8:0] expire_target;
	wire ready_now;
	wire [1:0] po_sel;

	assign po_sel = cal_cfg_q.power_on_expire_count;
	assign expire_target = (po_sel == 2'h0) ? rsmc_pkg::PO_EXP_0 :
		(po_sel == 2'h1) ? rsmc_pkg::PO_EXP_1 :
		(po_sel == 2'h2) ? rsmc_pkg::PO_EXP_2 : rsmc_pkg::PO_EXP_3;
	assign ready_now = (ripple_q == rsmc_pkg::RIPPLE_MAX) &&
		(expire_q + 9'h1 == expire_target);

	// counts clock cycles, so the wait scales with the crystal
	always_ff @(posedge mclk) begin
		if (srst || !crystal_s) begin
			ripple_q <= '0;
			expire_q <= '0;
			chip_ready_n <= 1'b1;
		end else begin
			ripple_q <= ripple_q + 6'h01;
			if (ripple_q == rsmc_pkg::RIPPLE_MAX) begin
				expire_q <= expire_q + 9'h001;
			end
			if (ready_now) begin
				chip_ready_n <= 1'b0;
			end
		end
	end

	// ======================================================
	// registered outputs
	// crystal stopped in sleep unless the keep-on bit is set
	always_ff @(posedge mclk) begin
		if (srst) begin
			radio_state <= rsmc_pkg::ST_IDLE;
			channel_clear_flag <= 1'b0;
			cal_start <= 1'b0;
			preamble_start <= 1'b0;
			crystal_oscillator_en <= 1'b1;
			pin_radio_control_en <= 1'b0;
		end else begin
			radio_state <= state_d;
			channel_clear_flag <= clear_d;
			cal_start <= cal_d;
			preamble_start <= preamble_d;
			crystal_oscillator_en <= (state_d != rsmc_pkg::ST_SLEEP) ||
				cal_cfg_q.crystal_keep_on_sleep;
			pin_radio_control_en <= cal_cfg_q.pin_radio_control_enable;
		end
	end

	// ======================================================
	// checks
	logic [14:0] run_q;

	// helper: cycles the synchronised crystal has been stable
	always_ff @(posedge mclk) begin
		if (srst || !crystal_s)
			run_q <= '0;
		else if (run_q != 15'h7fff)
			run_q <= run_q + 15'h0001;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_clear_always: assert property (
		clr_sel == rsmc_pkg::CLR_ALWAYS |=> channel_clear_flag)
		else $error("clear flag low in always mode");
	a_clear_both: assert property (
		clr_sel == rsmc_pkg::CLR_BOTH |=> channel_clear_flag ==
		($past(rssi_below_thresh) && !$past(pkt_receiving)))
		else $error("clear flag wrong in combined mode");
	a_rx_end_tx: assert property (
		radio_state == rsmc_pkg::ST_RX && evt.rx_end &&
		pkt_cfg_q.after_receive_next_state == rsmc_pkg::RXEND_TX
		|=> radio_state == rsmc_pkg::ST_TX)
		else $error("receive end did not go to transmit");
	a_tx_end_rx: assert property (
		radio_state == rsmc_pkg::ST_TX && evt.tx_end &&
		pkt_cfg_q.after_transmit_next_state == rsmc_pkg::TXEND_RX
		|=> radio_state == rsmc_pkg::ST_RX && !preamble_start)
		else $error("transmit end did not go to receive");
	a_cal_leave_idle: assert property (
		cal_mode == rsmc_pkg::CAL_FROM_IDLE &&
		radio_state == rsmc_pkg::ST_IDLE && cmd.go_rx
		|=> cal_start && radio_state == rsmc_pkg::ST_RX)
		else $error("no calibration on leaving idle");
	a_cal_every4: assert property (
		count_back && cal_cnt_q == rsmc_pkg::CAL_LAST |=> cal_start)
		else $error("no calibration on fourth return to idle");
	a_cal_count: assert property (
		count_back |=> cal_start == ($past(cal_cnt_q) == rsmc_pkg::CAL_LAST)
		&& cal_cnt_q == $past(cal_cnt_q) + 2'h1)
		else $error("fourth-return calibration count wrong");
	a_cal_hold: assert property (
		cal_mode != rsmc_pkg::CAL_EVERY4 |=> $stable(cal_cnt_q))
		else $error("return counter moved outside mode 3");
	a_ready_wait: assert property (
		$fell(chip_ready_n) && $stable(po_sel) |->
		run_q == {expire_target, 6'h00})
		else $error("ready came after the wrong expiry count");
	a_reg_write: assert property (
		wr_cal |=> cal_cfg_q == ($past(rx_byte) & rsmc_pkg::CFG_WMASK))
		else $error("register write or reserved mask wrong");
	a_crystal_sleep: assert property (
		radio_state == rsmc_pkg::ST_SLEEP &&
		$stable(cal_cfg_q.crystal_keep_on_sleep) |->
		crystal_oscillator_en == cal_cfg_q.crystal_keep_on_sleep)
		else $error("crystal enable wrong in sleep");
endmodule // rsmc_core

// ==== core/rsmc_sync.sv ====
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module rsmc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	// reset to the idle level so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // rsmc_sync

// ==== pkg/rsmc_pkg.sv ====
// constants, field layouts and types of the radio state machine configuration
package rsmc_pkg;
	// ======================================================
	// register map and reset values
	localparam logic [5:0] ADDR_PKT_CFG = 6'h17;
	localparam logic [5:0] ADDR_CAL_CFG = 6'h18;
	localparam logic [7:0] PKT_CFG_RST = 8'h30;
	localparam logic [7:0] CAL_CFG_RST = 8'h04;
	// bits 7:6 of both registers are reserved and read as zero
	localparam logic [7:0] CFG_WMASK = 8'h3f;
	localparam logic [7:0] RD_NONE = 8'h00;
	// idle pin levels {cs_n, sclk, mosi, crystal_stable} held in reset
	localparam logic [3:0] PIN_IDLE = 4'h8;

	// ======================================================
	// serial header layout and bit positions
	localparam int HDR_READ_BIT = 7;
	localparam int ADDR_MSB = 5;
	localparam logic [3:0] HDR_LAST = 4'h7;
	localparam logic [3:0] DATA_FIRST = 4'h8;
	localparam logic [3:0] DATA_LAST = 4'hf;

	// ======================================================
	// clear channel selection
	localparam logic [1:0] CLR_ALWAYS = 2'h0;
	localparam logic [1:0] CLR_RSSI = 2'h1;
	localparam logic [1:0] CLR_NO_PKT = 2'h2;
	localparam logic [1:0] CLR_BOTH = 2'h3;

	// ======================================================
	// next state after a received packet
	localparam logic [1:0] RXEND_IDLE = 2'h0;
	localparam logic [1:0] RXEND_SYNTH = 2'h1;
	localparam logic [1:0] RXEND_TX = 2'h2;
	localparam logic [1:0] RXEND_STAY = 2'h3;
	// next state after a sent packet
	localparam logic [1:0] TXEND_IDLE = 2'h0;
	localparam logic [1:0] TXEND_SYNTH = 2'h1;
	localparam logic [1:0] TXEND_STAY = 2'h2;
	localparam logic [1:0] TXEND_RX = 2'h3;

	// ======================================================
	// automatic synthesizer calibration
	localparam logic [1:0] CAL_NEVER = 2'h0;
	localparam logic [1:0] CAL_FROM_IDLE = 2'h1;
	localparam logic [1:0] CAL_TO_IDLE = 2'h2;
	localparam logic [1:0] CAL_EVERY4 = 2'h3;
	// returns to idle are counted 0..3, calibration on the fourth
	localparam logic [1:0] CAL_LAST = 2'h3;

	// ======================================================
	// power-on wait: six-bit ripple counter and expiry targets
	localparam logic [5:0] RIPPLE_MAX = 6'h3f;
	localparam logic [8:0] PO_EXP_0 = 9'h001;
	localparam logic [8:0] PO_EXP_1 = 9'h010;
	localparam logic [8:0] PO_EXP_2 = 9'h040;
	localparam logic [8:0] PO_EXP_3 = 9'h100;

	// ======================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_TX,
		ST_SYNTH_ON_TX_READY,
		ST_SLEEP
	} rsmc_state_e;

	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] clear_channel_select;
		logic [1:0] after_receive_next_state;
		logic [1:0] after_transmit_next_state;
	} rsmc_pkt_cfg_s;

	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] synth_auto_calibration;
		logic [1:0] power_on_expire_count;
		logic pin_radio_control_enable;
		logic crystal_keep_on_sleep;
	} rsmc_cal_cfg_s;

	// command strobes, one-cycle pulses from the radio controller
	typedef struct packed {
		logic go_rx;
		logic go_tx;
		logic go_synth;
		logic go_idle;
		logic go_sleep;
		logic calibrate_strobe;
	} rsmc_cmd_s;

	// packet end events, one-cycle pulses from the modem
	typedef struct packed {
		logic rx_end;
		logic tx_end;
	} rsmc_evt_s;
endpackage

// ==== sim/rsmc_host.sv ====
// host model: serial register master for the state machine configuration
`timescale 1ns/100ps
module rsmc_host (
	input wire logic mclk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	// ==============================================
	// serial frame master
	// each clock level lasts six mclk, above the four the port needs
	localparam int HALF = 6;
	logic oe_mid;

	// idle: frame deselected, serial clock parked low
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
		oe_mid = 1'b0;
	end

	// one header byte and one data byte, msb first
	task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge mclk);
		spi_cs_n <= 1'b0;
		repeat (HALF) @(posedge mclk);
		for (int i = 15; i >= 0; i--) begin
			spi_mosi <= word[i];
			repeat (HALF) @(posedge mclk);
			spi_sclk <= 1'b1;
			if (i < 8) begin
				rd[i] = spi_miso;
			end
			if (i == 0) begin
				oe_mid = spi_miso_oe;
			end
			repeat (HALF) @(posedge mclk);
			spi_sclk <= 1'b0;
		end
		repeat (HALF) @(posedge mclk);
		spi_cs_n <= 1'b1;
		// a released data line must not look like held data
		spi_mosi <= ~spi_mosi;
		repeat (8) @(posedge mclk);
	endtask
endmodule // rsmc_host

// ==== sim/tb_radio_state_machine_config.sv ====
// self-checking bench of the radio state machine configuration block
`timescale 1ns/100ps
module tb_radio_state_machine_config;
	// ==============================================
	// stimulus constants
	localparam logic [5:0] C_RX = 6'h20;
	localparam logic [5:0] C_TX = 6'h10;
	localparam logic [5:0] C_SLP = 6'h02;
	localparam logic [5:0] C_CAL = 6'h01;
	localparam logic [5:0] C_IDL = 6'h04;
	localparam logic [5:0] C_SYN = 6'h08;
	localparam logic [5:0] A_PKT = rsmc_pkg::ADDR_PKT_CFG;
	localparam logic [5:0] A_CAL = rsmc_pkg::ADDR_CAL_CFG;
	localparam int PO_N [4] = '{1, 16, 64, 256};
	localparam rsmc_pkg::rsmc_state_e RX_E [4] = '{rsmc_pkg::ST_IDLE,
		rsmc_pkg::ST_SYNTH_ON_TX_READY, rsmc_pkg::ST_TX, rsmc_pkg::ST_RX};
	localparam rsmc_pkg::rsmc_state_e TX_E [4] = '{rsmc_pkg::ST_IDLE,
		rsmc_pkg::ST_SYNTH_ON_TX_READY, rsmc_pkg::ST_TX, rsmc_pkg::ST_RX};

	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
	rsmc_pkg::rsmc_cmd_s cmd = '0;
	rsmc_pkg::rsmc_evt_s evt = '0;
	logic rssi_below_thresh = 1'b0;
	logic pkt_receiving = 1'b0;
	logic crystal_stable = 1'b0;
	logic channel_clear_flag, chip_ready_n, cal_start, preamble_start;
	logic crystal_oscillator_en, pin_radio_control_en;
	rsmc_pkg::rsmc_state_e radio_state;
	logic cal_seen, pre_seen;
	int error_cnt = 0;
	int checked = 0;

	// 10 MHz clock
	always #50 mclk = ~mclk;

	rsmc_core i_rsmc_core (.mclk(mclk), .srst(srst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .cmd(cmd), .evt(evt),
		.rssi_below_thresh(rssi_below_thresh), .pkt_receiving(pkt_receiving),
		.crystal_stable(crystal_stable),
		.channel_clear_flag(channel_clear_flag), .chip_ready_n(chip_ready_n),
		.radio_state(radio_state), .cal_start(cal_start),
		.preamble_start(preamble_start),
		.crystal_oscillator_en(crystal_oscillator_en),
		.pin_radio_control_en(pin_radio_control_en));

	rsmc_host i_rsmc_host (.mclk(mclk), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe));

	// ==============================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// sample just past the edge so the design's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic reset_dut();
		@(posedge mclk);
		srst <= 1'b1;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		tick(1);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		i_rsmc_host.xfer({2'b00, a, d}, r);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] r;
		i_rsmc_host.xfer({2'b10, a, 8'h00}, r);
		check(16'(r), 16'(e));
	endtask

	// one-cycle command or end-event pulse; outputs taken at the next edge
	task automatic strobe(input logic [5:0] c, input logic [1:0] e);
		@(posedge mclk);
		cmd <= c;
		evt <= e;
		@(posedge mclk);
		cmd <= '0;
		evt <= '0;
		#1;
		cal_seen = cal_start;
		pre_seen = preamble_start;
	endtask

	task automatic st_chk(input rsmc_pkg::rsmc_state_e e);
		check(16'(radio_state), 16'(e));
	endtask

	// ==============================================
	// scenarios
	task automatic t_reset();
		reset_dut();
		check(16'(chip_ready_n), 16'h1); // not ready yet
		check(16'(pin_radio_control_en), 16'h0); // pin control off
		check(16'(crystal_oscillator_en), 16'h1); // crystal running
		check(16'(spi_miso_oe), 16'h0); // port idle after reset
		st_chk(rsmc_pkg::ST_IDLE); // idle after reset
		rd_chk(A_PKT, 8'h30); // field defaults
		check(16'(i_rsmc_host.oe_mid), 16'h1); // driven during frame
		rd_chk(A_CAL, 8'h04); // field defaults
		rd_chk(6'h20, 8'h00); // unmapped reads zero
		wr(6'h20, 8'h15);
		rd_chk(A_PKT, 8'h30); // unmapped write dropped
		wr(A_PKT, 8'hff);
		rd_chk(A_PKT, 8'h3f); // reserved bits zero
		wr(A_CAL, 8'hc0);
		rd_chk(A_CAL, 8'h00); // reserved bits zero
		$display("test reset_and_map done");
	endtask

	task automatic t_clear();
		logic e;
		for (int m = 0; m < 4; m++) begin
			wr(A_PKT, {2'b00, 2'(m), 4'h0});
			for (int j = 0; j < 4; j++) begin
				@(posedge mclk);
				rssi_below_thresh <= j[0];
				pkt_receiving <= j[1];
				tick(3);
				e = (m == 0) | ((m == 1) & j[0]) | ((m == 2) & !j[1]);
				e = e | ((m == 3) & j[0] & !j[1]);
				check(16'(channel_clear_flag), 16'(e)); // clear value
			end
		end
		$display("test clear_channel done");
	endtask

	task automatic t_ends();
		for (int m = 0; m < 4; m++) begin
			reset_dut();
			wr(A_PKT, {4'h0, 2'(m), 2'(m)});
			strobe(C_RX, 2'b00);
			st_chk(rsmc_pkg::ST_RX); // receive entered
			strobe(6'h00, 2'b10);
			st_chk(RX_E[m]); // after receive
			reset_dut();
			wr(A_PKT, {4'h0, 2'(m), 2'(m)});
			strobe(C_TX, 2'b00);
			strobe(6'h00, 2'b01);
			st_chk(TX_E[m]); // after transmit
			check(16'(pre_seen), 16'(m == 2)); // preamble restart
		end
		$display("test packet_end done");
	endtask

	task automatic t_cal();
		reset_dut();
		strobe(C_RX, 2'b00);
		check(16'(cal_seen), 16'h0); // never automatic
		strobe(6'h00, 2'b10);
		check(16'(cal_seen), 16'h0); // never automatic
		strobe(C_CAL, 2'b00);
		check(16'(cal_seen), 16'h1); // manual strobe
		wr(A_CAL, 8'h14);
		strobe(C_RX, 2'b00);
		check(16'(cal_seen), 16'h1); // leaving idle
		strobe(6'h00, 2'b10);
		check(16'(cal_seen), 16'h0); // not on return
		strobe(C_SYN, 2'b00);
		check(16'(cal_seen), 16'h1); // idle to synth ready
		st_chk(rsmc_pkg::ST_SYNTH_ON_TX_READY); // synth ready reached
		strobe(C_IDL, 2'b00);
		check(16'(cal_seen), 16'h0); // not from synth ready
		st_chk(rsmc_pkg::ST_IDLE); // back from synth ready
		wr(A_CAL, 8'h24);
		strobe(C_TX, 2'b00);
		check(16'(cal_seen), 16'h0); // not on leaving
		strobe(6'h00, 2'b01);
		check(16'(cal_seen), 16'h1); // on return
		wr(A_CAL, 8'h34);
		for (int k = 1; k <= 8; k++) begin
			strobe(C_RX, 2'b00);
			check(16'(cal_seen), 16'h0); // quiet when leaving
			strobe(6'h00, 2'b10);
			check(16'(cal_seen), 16'(k % 4 == 0)); // fourth return
		end
		$display("test auto_calibration done");
	endtask

	task automatic t_power();
		reset_dut();
		for (int s = 0; s < 4; s++) begin
			wr(A_CAL, {4'h0, 2'(s), 2'b00});
			@(posedge mclk);
			crystal_stable <= 1'b0;
			tick(5);
			check(16'(chip_ready_n), 16'h1); // drops readiness
			@(posedge mclk);
			crystal_stable <= 1'b1;
			tick(PO_N[s] * 64 - 4);
			check(16'(chip_ready_n), 16'h1); // still waiting
			for (int k = 0; k < 16 && chip_ready_n !== 1'b0; k++) begin
				tick(1);
			end
			check(16'(chip_ready_n), 16'h0); // ready in time
		end
		$display("test power_on_wait done");
	endtask

	task automatic t_sleep();
		reset_dut();
		wr(A_CAL, 8'h06);
		check(16'(pin_radio_control_en), 16'h1); // pin control on
		strobe(C_SLP, 2'b00);
		st_chk(rsmc_pkg::ST_SLEEP); // sleep entered
		tick(2);
		check(16'(crystal_oscillator_en), 16'h0); // stops in sleep
		strobe(C_IDL, 2'b00);
		st_chk(rsmc_pkg::ST_IDLE); // wakes to idle
		check(16'(crystal_oscillator_en), 16'h1); // running again
		reset_dut();
		wr(A_CAL, 8'h05);
		strobe(C_SLP, 2'b00);
		tick(2);
		check(16'(crystal_oscillator_en), 16'h1); // kept on
		$display("test sleep_crystal done");
	endtask

	// ==============================================
	// main sequence and watchdog
	initial begin
		t_reset();
		t_clear();
		t_ends();
		t_cal();
		t_power();
		t_sleep();
		close_out();
	end

	// the run needs about 28000 cycles; cut a hang well beyond that
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		close_out();
	end
endmodule // tb_radio_state_machine_config
